/* File: csc_top.v */
`timescale 1ns/10ps
`include "csc_defines.vh"
// Functional notes
// - each module selects one of sixteen pins by four-bit channel field
// - enabled module connects oscillator to the selected pin
// - readable status shows oscillator sourcing or sinking
// - reference mode set picks variable references, clear picks rails
// - range 00 off or noise, 01 low, 10 medium, 11 high
// - noise mode stops pin current, oscillator circuitry stays on
// - comparator follows external noise, giving countable activity
// - oscillator A clocks paired counter or gated timer one, B likewise
// - gated timer clock source 11 selects sensing oscillator
// - gated timer off when on 0, free when gate 0, gated when 1
// - module enable on or off; disabled ignores channel, no pin
// - paired counter ext source picks oscillator or clock pin
// - oscillator keeps running in sleep while enabled
module csc_top (
    clk,
    rst_b,
    ce,
    haddr,
    htrans,
    hwrite,
    hsize,
    hwdata,
    hsel,
    hready,
    hreadyout,
    hrdata,
    hresp,
    comp_out_a,
    comp_out_b,
    ext_pin_a,
    ext_pin_b,
    paired_cs_a,
    paired_cs_b,
    gate_in_a,
    gate_in_b,
    pin_sel_a,
    pin_sel_b,
    osc_enable_a,
    osc_enable_b,
    ref_variable_a,
    ref_variable_b,
    range_code_a,
    range_code_b,
    src_sink_en_a,
    src_sink_en_b,
    paired_clk_sel_a,
    paired_clk_sel_b,
    paired_tick_a,
    paired_tick_b,
    gated_clk_sel_a,
    gated_clk_sel_b,
    gated_run_a,
    gated_run_b,
    gated_tick_a,
    gated_tick_b
);
    input wire clk;
    input wire rst_b;
    input wire ce;
    input wire [31:0] haddr;
    input wire [1:0] htrans;
    input wire hwrite;
    input wire [2:0] hsize;
    input wire [31:0] hwdata;
    input wire hsel;
    input wire hready;
    output wire hreadyout;
    output reg [31:0] hrdata;
    output wire hresp;
    input wire comp_out_a;
    input wire comp_out_b;
    input wire ext_pin_a;
    input wire ext_pin_b;
    input wire paired_cs_a;
    input wire paired_cs_b;
    input wire gate_in_a;
    input wire gate_in_b;
    output wire [`CSC_NPINS-1:0] pin_sel_a;
    output wire [`CSC_NPINS-1:0] pin_sel_b;
    output wire osc_enable_a;
    output wire osc_enable_b;
    output wire ref_variable_a;
    output wire ref_variable_b;
    output wire [1:0] range_code_a;
    output wire [1:0] range_code_b;
    output wire src_sink_en_a;
    output wire src_sink_en_b;
    output wire [1:0] paired_clk_sel_a;
    output wire [1:0] paired_clk_sel_b;
    output wire paired_tick_a;
    output wire paired_tick_b;
    output wire gated_clk_sel_a;
    output wire gated_clk_sel_b;
    output reg gated_run_a;
    output reg gated_run_b;
    output reg gated_tick_a;
    output reg gated_tick_b;

    // ==========================================================
    // register storage
    reg [7:0] ctrl0_a;
    reg [7:0] ctrl0_b;
    reg [3:0] chan_a;
    reg [3:0] chan_b;
    reg [7:0] gt_a;
    reg [7:0] gt_b;
    reg wr_pend;
    reg [`CSC_ADDR_W-1:0] wr_addr;
    wire osc_status_a;
    wire osc_status_b;
    wire gcnt_a;
    wire gcnt_b;
    wire gate_s_a;
    wire gate_s_b;
    wire addr_ph;
    wire [7:0] wbyte;
    reg [31:0] next_hrdata;

    // ==========================================================
    // ahb-lite slave: zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = `CSC_HRESP_OKAY;
    assign addr_ph = hsel && hready && (htrans == `CSC_HTRANS_NONSEQ || htrans[1]);
    assign wbyte = hwdata[7:0];

    // read mux, status bit reflects live oscillator state
    always @* begin
        next_hrdata = 32'h0000_0000;
        if (haddr[`CSC_ADDR_W-1:0] == `CSC_OFF_A_CTRL0) begin
            next_hrdata[7:0] = {ctrl0_a[7:2], osc_status_a, ctrl0_a[0]};
        end else if (haddr[`CSC_ADDR_W-1:0] == `CSC_OFF_A_CTRL1) begin
            next_hrdata[3:0] = chan_a;
        end else if (haddr[`CSC_ADDR_W-1:0] == `CSC_OFF_B_CTRL0) begin
            next_hrdata[7:0] = {ctrl0_b[7:2], osc_status_b, ctrl0_b[0]};
        end else if (haddr[`CSC_ADDR_W-1:0] == `CSC_OFF_B_CTRL1) begin
            next_hrdata[3:0] = chan_b;
        end else if (haddr[`CSC_ADDR_W-1:0] == `CSC_OFF_GT_A) begin
            next_hrdata[7:0] = gt_a;
        end else if (haddr[`CSC_ADDR_W-1:0] == `CSC_OFF_GT_B) begin
            next_hrdata[7:0] = gt_b;
        end
    end

    // address phase capture and read data
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_pend <= 1'b0;
            wr_addr <= {`CSC_ADDR_W{1'b0}};
            hrdata <= 32'h0000_0000;
        end else if (ce) begin
            wr_pend <= addr_ph && hwrite;
            wr_addr <= haddr[`CSC_ADDR_W-1:0];
            if (addr_ph && !hwrite) begin
                hrdata <= next_hrdata;
            end
        end
    end

    // data phase writes, reserved and status bits masked
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl0_a <= `CSC_RESET_BYTE;
            ctrl0_b <= `CSC_RESET_BYTE;
            chan_a <= 4'h0;
            chan_b <= 4'h0;
            gt_a <= `CSC_RESET_BYTE;
            gt_b <= `CSC_RESET_BYTE;
        end else if (ce && wr_pend) begin
            if (wr_addr == `CSC_OFF_A_CTRL0) begin
                ctrl0_a <= wbyte & `CSC_C0_WMASK;
            end else if (wr_addr == `CSC_OFF_A_CTRL1) begin
                chan_a <= wbyte[`CSC_C1_CH_HI:`CSC_C1_CH_LO];
            end else if (wr_addr == `CSC_OFF_B_CTRL0) begin
                ctrl0_b <= wbyte & `CSC_C0_WMASK;
            end else if (wr_addr == `CSC_OFF_B_CTRL1) begin
                chan_b <= wbyte[`CSC_C1_CH_HI:`CSC_C1_CH_LO];
            end else if (wr_addr == `CSC_OFF_GT_A) begin
                gt_a <= wbyte & `CSC_GT_WMASK;
            end else if (wr_addr == `CSC_OFF_GT_B) begin
                gt_b <= wbyte & `CSC_GT_WMASK;
            end
        end
    end

    // ==========================================================
    // the two sensing modules
    csc_module u_mod_a (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .ctrl0(ctrl0_a),
        .chan(chan_a),
        .gt_ctrl(gt_a),
        .paired_cs(paired_cs_a),
        .comp_out(comp_out_a),
        .ext_pin(ext_pin_a),
        .pin_sel(pin_sel_a),
        .osc_enable(osc_enable_a),
        .ref_variable(ref_variable_a),
        .range_code(range_code_a),
        .src_sink_en(src_sink_en_a),
        .osc_status(osc_status_a),
        .paired_clk_sel(paired_clk_sel_a),
        .paired_tick(paired_tick_a),
        .gated_clk_sel(gated_clk_sel_a),
        .gated_count_en(gcnt_a)
    );
    csc_module u_mod_b (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .ctrl0(ctrl0_b),
        .chan(chan_b),
        .gt_ctrl(gt_b),
        .paired_cs(paired_cs_b),
        .comp_out(comp_out_b),
        .ext_pin(ext_pin_b),
        .pin_sel(pin_sel_b),
        .osc_enable(osc_enable_b),
        .ref_variable(ref_variable_b),
        .range_code(range_code_b),
        .src_sink_en(src_sink_en_b),
        .osc_status(osc_status_b),
        .paired_clk_sel(paired_clk_sel_b),
        .paired_tick(paired_tick_b),
        .gated_clk_sel(gated_clk_sel_b),
        .gated_count_en(gcnt_b)
    );

    // gate inputs come from outside, synchronised first
    csc_sync u_gate_a (.clk(clk), .rst_b(rst_b), .ce(ce), .din(gate_in_a), .dout(gate_s_a));
    csc_sync u_gate_b (.clk(clk), .rst_b(rst_b), .ce(ce), .din(gate_in_b), .dout(gate_s_b));

    // ==========================================================
    // gated timer enable table
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gated_run_a <= 1'b0;
            gated_run_b <= 1'b0;
            gated_tick_a <= 1'b0;
            gated_tick_b <= 1'b0;
        end else if (ce) begin
            // off when on is 0, free when gate 0, gated when gate 1
            gated_run_a <= gt_a[`CSC_GT_ON] && (!gt_a[`CSC_GT_GE] || gate_s_a);
            gated_run_b <= gt_b[`CSC_GT_ON] && (!gt_b[`CSC_GT_GE] || gate_s_b);
            gated_tick_a <= gcnt_a && gated_clk_sel_a && (!gt_a[`CSC_GT_GE] || gate_s_a);
            gated_tick_b <= gcnt_b && gated_clk_sel_b && (!gt_b[`CSC_GT_GE] || gate_s_b);
        end
    end
endmodule

/* File: csc_defines.vh */
`ifndef CSC_DEFINES_VH
`define CSC_DEFINES_VH
// ==========================================================
// register map (byte addresses)
`define CSC_ADDR_W 8
`define CSC_OFF_A_CTRL0 8'h00
`define CSC_OFF_A_CTRL1 8'h04
`define CSC_OFF_B_CTRL0 8'h08
`define CSC_OFF_B_CTRL1 8'h0C
`define CSC_OFF_GT_A 8'h10
`define CSC_OFF_GT_B 8'h14
// ==========================================================
// sense_control_zero fields
`define CSC_C0_ON 7
`define CSC_C0_RM 6
`define CSC_C0_RNG_HI 3
`define CSC_C0_RNG_LO 2
`define CSC_C0_OUT 1
`define CSC_C0_XCS 0
`define CSC_C0_WMASK 8'hCD
// sense_control_one fields
`define CSC_C1_CH_HI 3
`define CSC_C1_CH_LO 0
// gated timer control fields (own layout)
`define CSC_GT_CS_HI 5
`define CSC_GT_CS_LO 4
`define CSC_GT_GE 1
`define CSC_GT_ON 0
`define CSC_GT_WMASK 8'h33
// ==========================================================
// codes
`define CSC_RNG_OFF 2'h0
`define CSC_GT_CS_OSC 2'h3
`define CSC_RESET_BYTE 8'h00
`define CSC_HRESP_OKAY 1'b0
`define CSC_HTRANS_NONSEQ 2'h2
`define CSC_NPINS 16
`endif

/* File: csc_sync.v */
`timescale 1ns/10ps
`include "csc_defines.vh"
// ==========================================================
// two-flop synchroniser for one level
module csc_sync (
    clk,
    rst_b,
    ce,
    din,
    dout
);
    input wire clk;
    input wire rst_b;
    input wire ce;
    input wire din;
    output reg dout;
    reg stage1;
    // first stage feeds only the second
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= 1'b0;
            dout <= 1'b0;
        end else if (ce) begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule

/* File: csc_module.v */
`timescale 1ns/10ps
`include "csc_defines.vh"
// ==========================================================
// one sensing module: pin mux, range decode, clock routing
module csc_module (
    clk,
    rst_b,
    ce,
    ctrl0,
    chan,
    gt_ctrl,
    paired_cs,
    comp_out,
    ext_pin,
    pin_sel,
    osc_enable,
    ref_variable,
    range_code,
    src_sink_en,
    osc_status,
    paired_clk_sel,
    paired_tick,
    gated_clk_sel,
    gated_count_en
);
    input wire clk;
    input wire rst_b;
    input wire ce;
    input wire [7:0] ctrl0;
    input wire [3:0] chan;
    input wire [7:0] gt_ctrl;
    input wire paired_cs;
    input wire comp_out;
    input wire ext_pin;
    output reg [`CSC_NPINS-1:0] pin_sel;
    output reg osc_enable;
    output reg ref_variable;
    output reg [1:0] range_code;
    output reg src_sink_en;
    output wire osc_status;
    output reg [1:0] paired_clk_sel;
    output reg paired_tick;
    output reg gated_clk_sel;
    output reg gated_count_en;
    wire on_bit;
    wire rm;
    wire [1:0] rng;
    wire osc_s;
    wire pin_s;
    reg osc_d;
    reg pin_d;
    wire osc_rise;
    wire pin_rise;
    wire noise_mode;
    assign on_bit = ctrl0[`CSC_C0_ON];
    assign rm = ctrl0[`CSC_C0_RM];
    assign rng = ctrl0[`CSC_C0_RNG_HI:`CSC_C0_RNG_LO];
    assign noise_mode = rm && (rng == `CSC_RNG_OFF);
    // comparator and timer pin through synchronisers
    csc_sync u_osc (.clk(clk), .rst_b(rst_b), .ce(ce), .din(comp_out), .dout(osc_s));
    csc_sync u_pin (.clk(clk), .rst_b(rst_b), .ce(ce), .din(ext_pin), .dout(pin_s));
    assign osc_status = osc_s;
    assign osc_rise = osc_s && !osc_d;
    assign pin_rise = pin_s && !pin_d;
    // edge history
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_d <= 1'b0;
            pin_d <= 1'b0;
        end else if (ce) begin
            osc_d <= osc_s;
            pin_d <= pin_s;
        end
    end
    // registered analog controls and counter ticks
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_sel <= {`CSC_NPINS{1'b0}};
            osc_enable <= 1'b0;
            ref_variable <= 1'b0;
            range_code <= `CSC_RNG_OFF;
            src_sink_en <= 1'b0;
            paired_clk_sel <= 2'h0;
            paired_tick <= 1'b0;
            gated_clk_sel <= 1'b0;
            gated_count_en <= 1'b0;
        end else if (ce) begin
            // one-hot pin select, none while disabled; runs in sleep too
            pin_sel <= on_bit ? ({{(`CSC_NPINS-1){1'b0}}, 1'b1} << chan) : {`CSC_NPINS{1'b0}};
            ref_variable <= rm;
            range_code <= rng;
            // reference mode clear with range 00 is off; set with range 00 keeps oscillator on
            osc_enable <= on_bit && (rm || (rng != `CSC_RNG_OFF));
            src_sink_en <= on_bit && (rng != `CSC_RNG_OFF);
            // 0 = instruction clock, 1 = ext pin, 2 = oscillator
            if (!paired_cs) begin
                paired_clk_sel <= 2'h0;
                paired_tick <= 1'b1;
            end else if (ctrl0[`CSC_C0_XCS]) begin
                paired_clk_sel <= 2'h2;
                paired_tick <= osc_rise;
            end else begin
                paired_clk_sel <= 2'h1;
                paired_tick <= pin_rise;
            end
            gated_clk_sel <= (gt_ctrl[`CSC_GT_CS_HI:`CSC_GT_CS_LO] == `CSC_GT_CS_OSC);
            gated_count_en <= gt_ctrl[`CSC_GT_ON] && (osc_rise || noise_mode && osc_rise);
        end
    end
endmodule

/* File: csc_chk_asserts.sv */
`timescale 1ns/10ps
// ====================
// checker on the module A outputs
module csc_chk (
    input wire clk,
    input wire rst_b,
    input wire [15:0] pin_sel_a,
    input wire osc_enable_a,
    input wire ref_variable_a,
    input wire [1:0] range_code_a,
    input wire src_sink_en_a,
    input wire [1:0] paired_clk_sel_a,
    input wire paired_tick_a,
    input wire gated_clk_sel_a,
    input wire gated_run_a,
    input wire gated_tick_a
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_onehot; $onehot0(pin_sel_a); endproperty
    a_onehot: assert property (p_onehot) else $error("pin select not one-hot");
    property p_pin; src_sink_en_a |-> $onehot(pin_sel_a); endproperty
    a_pin: assert property (p_pin) else $error("running oscillator has no pin");
    property p_rng; src_sink_en_a |-> range_code_a != 2'h0 && osc_enable_a; endproperty
    a_rng: assert property (p_rng) else $error("current on in range zero");
    property p_off; !ref_variable_a && range_code_a == 2'h0 |-> !osc_enable_a; endproperty
    a_off: assert property (p_off) else $error("oscillator on in low range off");
    property p_noise;
        |pin_sel_a && ref_variable_a && range_code_a == 2'h0 |-> osc_enable_a && !src_sink_en_a;
    endproperty
    a_noise: assert property (p_noise) else $error("noise mode wrong");
    property p_instr; paired_clk_sel_a == 2'h0 [*3] |-> paired_tick_a; endproperty
    a_instr: assert property (p_instr) else $error("instruction clock tick missing");
    property p_psel; paired_clk_sel_a != 2'h3; endproperty
    a_psel: assert property (p_psel) else $error("paired source code reserved");
    property p_gtick;
        gated_tick_a |-> (gated_run_a || $past(gated_run_a) || $past(gated_run_a, 2))
            && (gated_clk_sel_a || $past(gated_clk_sel_a));
    endproperty
    a_gtick: assert property (p_gtick) else $error("gated tick while stopped");
    property p_pulse; gated_tick_a |=> !gated_tick_a; endproperty
    a_pulse: assert property (p_pulse) else $error("gated tick too long");
endmodule

bind csc_top csc_chk i_chk (.clk(clk), .rst_b(rst_b), .pin_sel_a(pin_sel_a),
    .osc_enable_a(osc_enable_a), .ref_variable_a(ref_variable_a), .range_code_a(range_code_a),
    .src_sink_en_a(src_sink_en_a), .paired_clk_sel_a(paired_clk_sel_a),
    .paired_tick_a(paired_tick_a), .gated_clk_sel_a(gated_clk_sel_a),
    .gated_run_a(gated_run_a), .gated_tick_a(gated_tick_a));

/* File: csc_pad.sv */
`timescale 1ns/10ps
// ====================
// touch pad and counter clock pin
module csc_pad #(parameter int HALF = 40) (
    input wire src_sink_en,
    input wire osc_enable,
    input wire pin_ok,
    input wire noise,
    input wire level,
    output logic comp_out,
    output logic ext_pin
);
    initial comp_out = 1'h0;
    initial ext_pin = 1'h0;
    // comparator swings only with current or noise on a set-up pin
    always begin
        #(HALF);
        if (osc_enable && pin_ok && (src_sink_en || noise)) comp_out = ~comp_out;
        else comp_out = level;
    end
    // free running counter clock pin
    always #(HALF * 3 / 2) ext_pin = ~ext_pin;
endmodule

/* File: test_capacitive_sense_control.sv */
`timescale 1ns/10ps
`include "csc_defines.vh"
// ====================
// bench for the sensing control block
module test_capacitive_sense_control;
    logic clk = 1'h0, rst_b = 1'h0, ce = 1'h1, hwrite = 1'h0, hsel = 1'h1, e;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, w;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp, pin_ok = 1'h1, noise = 1'h0, level = 1'h0;
    logic comp_out_a, comp_out_b, ext_pin_a, ext_pin_b, gate_in_a = 1'h0, gate_in_b = 1'h0;
    logic paired_cs_a = 1'h1, paired_cs_b = 1'h1;
    logic [15:0] pin_sel_a, pin_sel_b;
    logic osc_enable_a, osc_enable_b, ref_variable_a, ref_variable_b, src_sink_en_a, src_sink_en_b;
    logic [1:0] range_code_a, range_code_b, paired_clk_sel_a, paired_clk_sel_b;
    logic paired_tick_a, paired_tick_b, gated_clk_sel_a, gated_clk_sel_b;
    logic gated_run_a, gated_run_b, gated_tick_a, gated_tick_b;
    int bad_count = 0, n_tests = 0, cnt = 0, m = 0;
    wire [23:0] ob_a = {pin_sel_a, osc_enable_a, ref_variable_a, range_code_a, src_sink_en_a,
        paired_clk_sel_a, gated_clk_sel_a};
    wire [23:0] ob_b = {pin_sel_b, osc_enable_b, ref_variable_b, range_code_b, src_sink_en_b,
        paired_clk_sel_b, gated_clk_sel_b};
    assign hready = hreadyout;
    csc_top i_dut (.clk, .rst_b, .ce, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hsel, .hready,
        .hreadyout, .hrdata, .hresp, .comp_out_a, .comp_out_b, .ext_pin_a, .ext_pin_b,
        .paired_cs_a, .paired_cs_b, .gate_in_a, .gate_in_b, .pin_sel_a, .pin_sel_b,
        .osc_enable_a, .osc_enable_b, .ref_variable_a, .ref_variable_b, .range_code_a,
        .range_code_b, .src_sink_en_a, .src_sink_en_b, .paired_clk_sel_a, .paired_clk_sel_b,
        .paired_tick_a, .paired_tick_b, .gated_clk_sel_a, .gated_clk_sel_b, .gated_run_a,
        .gated_run_b, .gated_tick_a, .gated_tick_b);
    csc_pad i_pad_a (.src_sink_en(src_sink_en_a), .osc_enable(osc_enable_a), .pin_ok, .noise,
        .level, .comp_out(comp_out_a), .ext_pin(ext_pin_a));
    csc_pad i_pad_b (.src_sink_en(src_sink_en_b), .osc_enable(osc_enable_b), .pin_ok, .noise,
        .level, .comp_out(comp_out_b), .ext_pin(ext_pin_b));
    always #2.5 clk = ~clk;
    // counts gated ticks of the module under test
    always @(posedge clk) if (m ? gated_tick_b : gated_tick_a) cnt <= cnt + 1;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one single transfer, held until ready is seen
    task ahb(input logic [7:0] a, input logic wr_en, input logic [31:0] wd);
        haddr <= {24'h0, a};
        htrans <= `CSC_HTRANS_NONSEQ;
        hwrite <= wr_en;
        do @(posedge clk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'h1);
        rd = hrdata;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        ahb(a, 1'h1, d);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] x, input logic [31:0] msk);
        ahb(a, 1'h0, 32'h0);
        chk(rd & msk, x);
    endtask
    task cko(input logic [23:0] x);
        repeat (2) @(posedge clk);
        #1;
        chk(m ? ob_b : ob_a, x);
    endtask
    // window timed by the bench, not by the timer being clocked
    task meas(input logic x);
        int s;
        repeat (10) @(posedge clk);
        s = cnt;
        repeat (80) @(posedge clk);
        chk(cnt != s, x);
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        give_verdict;
    end
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'h1;
        @(posedge clk);
        wr(8'h18, 32'hFF);
        for (int a = 0; a < 32; a += 4) rdc(a, 32'h0, 32'hFFFFFFFF);
        for (m = 0; m < 2; m++) begin
            for (int i = 0; i < 16; i++) begin
                w = 32'h80 | i[3] << 6 | i[1:0] << 2 | i[2];
                wr(m * 8 + 4, 32'hF0 | i);
                wr(m * 8, w | 32'h32);
                rdc(m * 8 + 4, i, 32'hFF);
                rdc(m * 8, w, 32'hFD);
                cko({16'h1 << i, i[3] | (|i[1:0]), i[3], i[1:0], |i[1:0], i[2] ? 2'h2 : 2'h1, 1'h0});
            end
            wr(m * 8, 32'h0);
            cko({16'h0, 8'h02});
            wr(m * 8, 32'h80);
            level = 1'h1;
            repeat (12) @(posedge clk);
            rdc(m * 8, 32'h82, 32'hFF);
            level = 1'h0;
            repeat (12) @(posedge clk);
            rdc(m * 8, 32'h80, 32'hFF);
            if (m) paired_cs_b <= 1'h0;
            else paired_cs_a <= 1'h0;
            cko({16'h8000, 8'h00});
            chk(m ? paired_tick_b : paired_tick_a, 32'h1);
            chk({hreadyout, hresp}, 32'h2);
            wr(8'h10 + m * 4, 32'hFF);
            rdc(8'h10 + m * 4, 32'h33, 32'hFF);
            wr(m * 8, 32'hC4);
            for (int j = 0; j < 16; j++) begin
                e = j[0] & (~j[1] | j[2]);
                if (m) gate_in_b <= j[2];
                else gate_in_a <= j[2];
                wr(8'h10 + m * 4, (j[3] ? 32'h0 : 32'h30) | j[1:0]);
                meas(e & ~j[3]);
                chk(m ? gated_run_b : gated_run_a, e);
            end
            wr(8'h10 + m * 4, 32'h31);
            wr(m * 8, 32'hC0);
            noise = 1'h1;
            meas(1'h1);
            noise = 1'h0;
            meas(1'h0);
            wr(m * 8, 32'h0);
        end
        give_verdict;
    end
endmodule
